// File: src/csf_map.vh
// register offsets, field positions, reset values for the cpu status flags block
`ifndef CSF_MAP_VH
`define CSF_MAP_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define CSF_OFF_STATUS     12'h000
`define CSF_OFF_CORECFG    12'h004
`define CSF_OFF_IRQCFG     12'h008
`define CSF_OFF_GATE       12'h00c

// ****************************************
// status word, core config and irq config field positions
// ****************************************
`define CSF_BIT_CARRY      0
`define CSF_BIT_ZERO       1
`define CSF_BIT_WRAP       2
`define CSF_BIT_NEG        3
`define CSF_BIT_LOOP       4
`define CSF_IPL_LO         5
`define CSF_IPL_HI         7
`define CSF_BIT_EITHER     8
`define CSF_BIT_ACCB       9
`define CSF_BIT_ACCA       10
`define CSF_BIT_IPL3       3
`define CSF_BIT_NEST_OFF   15

// ****************************************
// reset values and constants
// ****************************************
`define CSF_IPL_RESET      3'h0
`define CSF_IPL_MAX        3'h7
`define CSF_STATUS_RESET   16'h0000

`endif

// File: src/csf_cpu_status_flags.v
// cpu status flags word: priority level, loop flag, alu flags, apb access
// Notes on behaviour
// - bits 7..5 hold the three-bit priority level, 000 to 111 meaning levels 0 to 7.
// - a three-bit level of 111 blocks all user interrupts.
// - core config bit 3 sits above the field to give an effective level 0 to 15.
// - while core config bit 3 is one, user interrupts are blocked whatever the field holds.
// - while the nesting-off bit (irq config bit 15) is one, data writes to the level field are ignored; interrupt controller loads still apply.
// - bit 4 is one while a single-instruction repeat loop runs, zero otherwise.
// - bit 3 is set by a negative result and cleared by a zero or positive one.
// - bit 2 is set on signed two's-complement overflow and cleared otherwise.
// - bit 1 is cleared by a non-zero result and set by a zero result, and kept otherwise.
// - bit 0 is set by a carry out of the result msb (borrow sense) and cleared otherwise.
// - a data write may set or clear both clip flags directly, or clear both by clearing bit 8.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`include "csf_map.vh"

module csf_cpu_status_flags #(
    parameter ADDR_W = 12
) (
    // clock and reset
    input  wire              clk,
    input  wire              arst_n,
    // apb slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    input  wire [3:0]        pstrb,
    output wire              pready,
    output reg  [31:0]       prdata,
    output wire              pslverr,
    // instruction completion from the execute stage
    input  wire              instDone,
    input  wire              affectNeg,
    input  wire              affectWrap,
    input  wire              affectZero,
    input  wire              affectCarry,
    input  wire              resNeg,
    input  wire              resWrap,
    input  wire              resZero,
    input  wire              resCarry,
    // repeat loop state
    input  wire              loopRunning,
    // accumulator clip events from the dsp unit
    input  wire              accAClipSet,
    input  wire              accBClipSet,
    // level updates from the interrupt controller
    input  wire              iplLoad,
    input  wire [2:0]        iplLoadValue,
    // status outputs
    output wire [15:0]       statusWord,
    output wire [3:0]        effectiveLevel,
    output wire              userIrqBlocked
);

    // ****************************************
    // state
    // ****************************************
    reg  [2:0]  iplQ;
    reg  [2:0]  iplD;
    reg         loopQ;
    reg         negQ;
    reg         negD;
    reg         wrapQ;
    reg         wrapD;
    reg         zeroQ;
    reg         zeroD;
    reg         carryQ;
    reg         carryD;
    reg         accAQ;
    reg         accAD;
    reg         accBQ;
    reg         accBD;
    reg  [15:0] coreCfgQ;
    reg  [15:0] irqCfgQ;
    reg  [15:0] coreCfgD;
    reg  [15:0] irqCfgD;
    reg  [31:0] rdD;

    // ****************************************
    // decode and view nets
    // ****************************************
    wire        wrEn;
    wire        mapped;
    wire        wrStatus;
    wire        wrLo;
    wire        wrHi;
    wire        nestOff;
    wire        wrCoreCfg;
    wire        wrIrqCfg;
    wire        selStatus;
    wire        selCoreCfg;
    wire        selIrqCfg;
    wire        selGate;
    wire        levelIsMax;
    wire        extBitSet;
    wire [7:0]  statusLo;
    wire [7:0]  statusHi;
    wire [31:0] gateWord;

    // ****************************************
    // apb decode
    // ****************************************
    // zero wait states; unmapped addresses answer with an error
    assign selStatus  = (paddr == `CSF_OFF_STATUS);
    assign selCoreCfg = (paddr == `CSF_OFF_CORECFG);
    assign selIrqCfg  = (paddr == `CSF_OFF_IRQCFG);
    assign selGate    = (paddr == `CSF_OFF_GATE);
    assign pready     = 1'b1;
    assign mapped     = selStatus | selCoreCfg | selIrqCfg | selGate;
    assign pslverr    = psel & penable & ~mapped;
    assign wrEn       = psel & penable & pwrite & mapped;
    assign wrStatus   = wrEn & selStatus;
    assign wrCoreCfg  = wrEn & selCoreCfg;
    assign wrIrqCfg   = wrEn & selIrqCfg;
    assign wrLo       = wrStatus & pstrb[0];
    assign wrHi       = wrStatus & pstrb[1];
    assign nestOff    = irqCfgQ[`CSF_BIT_NEST_OFF];

    // ****************************************
    // status word view
    // ****************************************
    assign statusLo       = {iplQ, loopQ, negQ, wrapQ, zeroQ, carryQ};
    assign statusHi       = {5'h00, accAQ, accBQ, accAQ | accBQ};
    assign statusWord     = {statusHi, statusLo};
    assign effectiveLevel = {coreCfgQ[`CSF_BIT_IPL3], iplQ};
    assign levelIsMax     = (iplQ == `CSF_IPL_MAX);
    assign extBitSet      = coreCfgQ[`CSF_BIT_IPL3];
    assign userIrqBlocked = extBitSet | levelIsMax;
    assign gateWord       = {27'h0000000, userIrqBlocked, effectiveLevel};

    // ****************************************
    // level field next state
    // ****************************************
    // the controller's load is applied last so it beats a software store
    always @* begin
        iplD = iplQ;
        if (wrLo && !nestOff) begin
            iplD = pwdata[`CSF_IPL_HI:`CSF_IPL_LO];
        end
        if (iplLoad) begin
            iplD = iplLoadValue;
        end
    end

    // ****************************************
    // clip flags next state
    // ****************************************
    always @* begin
        accAD = accAQ;
        accBD = accBQ;
        if (wrHi) begin
            accAD = pwdata[`CSF_BIT_ACCA];
            accBD = pwdata[`CSF_BIT_ACCB];
            if (!pwdata[`CSF_BIT_EITHER]) begin
                accAD = 1'b0;
                accBD = 1'b0;
            end
        end
        // a racing clip event beats the software clear; bit operations would lose it
        if (accAClipSet) begin
            accAD = 1'b1;
        end
        if (accBClipSet) begin
            accBD = 1'b1;
        end
    end

    // ****************************************
    // alu flags next state
    // ****************************************
    // software stores first, results after so hardware wins the cycle
    always @* begin
        negD   = negQ;
        wrapD  = wrapQ;
        zeroD  = zeroQ;
        carryD = carryQ;
        if (wrLo) begin
            negD   = pwdata[`CSF_BIT_NEG];
            wrapD  = pwdata[`CSF_BIT_WRAP];
            zeroD  = pwdata[`CSF_BIT_ZERO];
            carryD = pwdata[`CSF_BIT_CARRY];
        end
        if (instDone && affectNeg) begin
            negD = resNeg;
        end
        if (instDone && affectWrap) begin
            wrapD = resWrap;
        end
        if (instDone && affectZero) begin
            zeroD = resZero;
        end
        if (instDone && affectCarry) begin
            carryD = resCarry;
        end
    end

    // ****************************************
    // configuration words
    // ****************************************
    // byte lanes are honoured so a half-word store leaves the other half alone
    always @* begin
        coreCfgD = coreCfgQ;
        if (wrCoreCfg && pstrb[0]) begin
            coreCfgD[7:0] = pwdata[7:0];
        end
        if (wrCoreCfg && pstrb[1]) begin
            coreCfgD[15:8] = pwdata[15:8];
        end
    end

    always @* begin
        irqCfgD = irqCfgQ;
        if (wrIrqCfg && pstrb[0]) begin
            irqCfgD[7:0] = pwdata[7:0];
        end
        if (wrIrqCfg && pstrb[1]) begin
            irqCfgD[15:8] = pwdata[15:8];
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // one process per field keeps each reset value beside its flop
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            iplQ <= `CSF_IPL_RESET;
        end else begin
            iplQ <= iplD;
        end
    end

    // registered, so the bit lags the loop state by one cycle
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loopQ <= 1'b0;
        end else begin
            loopQ <= loopRunning;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            negQ <= 1'b0;
        end else begin
            negQ <= negD;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrapQ <= 1'b0;
        end else begin
            wrapQ <= wrapD;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            zeroQ <= 1'b0;
        end else begin
            zeroQ <= zeroD;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            carryQ <= 1'b0;
        end else begin
            carryQ <= carryD;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            accAQ <= 1'b0;
        end else begin
            accAQ <= accAD;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            accBQ <= 1'b0;
        end else begin
            accBQ <= accBD;
        end
    end

    // core config: only bit 3 is used here, the rest is plain storage
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            coreCfgQ <= `CSF_STATUS_RESET;
        end else begin
            coreCfgQ <= coreCfgD;
        end
    end

    // irq config: only bit 15 is used here, the rest is plain storage
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irqCfgQ <= `CSF_STATUS_RESET;
        end else begin
            irqCfgQ <= irqCfgD;
        end
    end

    // ****************************************
    // read data
    // ****************************************
    // the word is captured in the setup cycle so it stands through the access
    always @* begin
        case (paddr)
            `CSF_OFF_STATUS: begin
                rdD = {16'h0000, statusWord};
            end
            `CSF_OFF_CORECFG: begin
                rdD = {16'h0000, coreCfgQ};
            end
            `CSF_OFF_IRQCFG: begin
                rdD = {16'h0000, irqCfgQ};
            end
            `CSF_OFF_GATE: begin
                rdD = gateWord;
            end
            default: begin
                rdD = 32'h00000000;
            end
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdD;
        end
    end

endmodule // csf_cpu_status_flags

// File: dv/csf_flags_sva.sv
// port-level assertions for the cpu status flags block
module csf_flags_sva (
    // clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // apb controls
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    // execute side
    input wire logic        instDone,
    input wire logic        affectNeg,
    input wire logic        affectWrap,
    input wire logic        affectZero,
    input wire logic        affectCarry,
    input wire logic        resNeg,
    input wire logic        resWrap,
    input wire logic        resZero,
    input wire logic        resCarry,
    input wire logic        loopRunning,
    input wire logic        accAClipSet,
    // status view
    input wire logic [15:0] statusWord,
    input wire logic [3:0]  effectiveLevel,
    input wire logic        userIrqBlocked
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // properties
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence flagOp(a);
        instDone && a;
    endsequence
    chk_level_view: assert property (effectiveLevel[2:0] == statusWord[7:5])
        else $error("level field and effective level differ");
    chk_irq_block: assert property (userIrqBlocked == (effectiveLevel[3] || statusWord[7:5] == 3'h7))
        else $error("user interrupt block wrong");
    chk_loop_flag: assert property (1'b1 |=> statusWord[4] == $past(loopRunning))
        else $error("loop flag does not follow loop state");
    chk_neg_update: assert property (flagOp(affectNeg) |=> statusWord[3] == $past(resNeg))
        else $error("negative flag not updated");
    chk_wrap_update: assert property (flagOp(affectWrap) |=> statusWord[2] == $past(resWrap))
        else $error("overflow flag not updated");
    chk_zero_update: assert property (flagOp(affectZero) |=> statusWord[1] == $past(resZero))
        else $error("zero flag not updated");
    chk_carry_update: assert property (flagOp(affectCarry) |=> statusWord[0] == $past(resCarry))
        else $error("carry flag not updated");
    chk_flag_hold: assert property (!instDone && !(psel && penable && pwrite) |=> $stable(statusWord[3:0]))
        else $error("alu flags changed without cause");
    chk_clip_set: assert property (accAClipSet |=> statusWord[10] && statusWord[8])
        else $error("clip event not recorded");
endmodule // csf_flags_sva

bind csf_cpu_status_flags csf_flags_sva csf_flags_sva_inst (.*);

// File: dv/cpu_status_flags_tb.sv
// self-checking bench for the cpu status flags block
`include "csf_map.vh"
module cpu_status_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, instDone = 0, err;
    logic        affectNeg = 0, affectWrap = 0, affectZero = 0, affectCarry = 0, loopRunning = 0;
    logic        resNeg = 0, resWrap = 0, resZero = 0, resCarry = 0, iplLoad = 0;
    logic        accAClipSet = 0, accBClipSet = 0, pready, pslverr, userIrqBlocked;
    logic [2:0]  iplLoadValue = 0;
    logic [3:0]  pstrb = 4'hf, effectiveLevel;
    logic [11:0] paddr = 0, rows [6] = '{12'hfaa, 12'h11b, 12'h209, 12'h0f9, 12'hc45, 12'hf00};
    logic [15:0] statusWord;
    logic [31:0] pwdata = 0, rd, prdata;
    int          bad_count = 0, checked = 0, cyc = 0;
    csf_cpu_status_flags csf_cpu_status_flags_inst (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .instDone(instDone), .affectNeg(affectNeg),
        .affectWrap(affectWrap), .affectZero(affectZero), .affectCarry(affectCarry),
        .resNeg(resNeg), .resWrap(resWrap), .resZero(resZero), .resCarry(resCarry),
        .loopRunning(loopRunning), .accAClipSet(accAClipSet), .accBClipSet(accBClipSet),
        .iplLoad(iplLoad), .iplLoadValue(iplLoadValue), .statusWord(statusWord),
        .effectiveLevel(effectiveLevel), .userIrqBlocked(userIrqBlocked)
    );
    always #5 clk = ~clk;
    // ****
    // tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(negedge clk);
    endtask
    // row: affect nibble, result nibble, expected flags; flags not affected must hold
    task automatic op(input logic [7:0] v);
        @(posedge clk);
        {affectNeg, affectWrap, affectZero, affectCarry, resNeg, resWrap, resZero, resCarry} <= v;
        instDone <= 1;
        @(posedge clk);
        instDone <= 0;
        @(negedge clk);
    endtask
    task summarize;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            summarize;
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1;
        @(negedge clk);
        chk(statusWord, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            op(rows[i][11:4]);
            chk(statusWord[3:0], rows[i][3:0]);
        end
        for (int i = 1; i >= 0; i--) begin
            @(posedge clk);
            loopRunning <= i[0];
            @(posedge clk);
            @(negedge clk);
            chk(statusWord[4], i[0]);
        end
        xfer(1, `CSF_OFF_STATUS, 32'h00e0);
        chk({userIrqBlocked, effectiveLevel}, 5'h17);
        xfer(1, `CSF_OFF_STATUS, 32'h0040);
        xfer(1, `CSF_OFF_CORECFG, 32'h0008);
        chk({userIrqBlocked, effectiveLevel}, 5'h1a);
        xfer(1, `CSF_OFF_IRQCFG, 32'h8000);
        xfer(1, `CSF_OFF_STATUS, 32'h00e0);
        chk(statusWord[7:5], 3'h2);
        @(posedge clk);
        iplLoad <= 1;
        iplLoadValue <= 3'h5;
        @(posedge clk);
        iplLoad <= 0;
        xfer(0, `CSF_OFF_STATUS, 32'h0);
        chk(rd, 32'h00a0);
        @(posedge clk);
        {accAClipSet, accBClipSet} <= 2'b11;
        @(posedge clk);
        {accAClipSet, accBClipSet} <= 2'b00;
        @(negedge clk);
        chk(statusWord[10:8], 3'h7);
        xfer(1, `CSF_OFF_STATUS, 32'h00a0);
        chk(statusWord[10:8], 3'h0);
        xfer(0, 12'h010, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        chk(pready, 1'b1);
        // reset in mid-run: level 5 and core config bit 3 are set before it
        @(posedge clk);
        arst_n <= 0;
        @(negedge clk);
        chk(statusWord, 16'h0000);
        chk({userIrqBlocked, effectiveLevel}, 5'h00);
        @(posedge clk);
        arst_n <= 1;
        @(negedge clk);
        chk(statusWord, 16'h0000);
        summarize;
    end
endmodule // cpu_status_flags_tb
